// File: rtl/dcc_chan.sv
// One comparator channel: gating, polarity, latching, sync and edge flag
`timescale 1ns/10ps
module dcc_chan
   import dcc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic raw_cmp,
   input wire logic cmp_on,
   input wire logic invert,
   input wire logic sync_en,
   input wire logic tmr_fall,
   input wire logic rise_en,
   input wire logic fall_en,
   input wire logic flag_clr,
   output logic result_r,
   output logic pin_val_r,
   output logic flag_r
);
   logic prev_r;
   logic sync_r;
   logic gated;
   logic result_nxt;
   logic prev_nxt;
   logic sync_nxt;
   logic flag_nxt;
   logic pin_nxt;
   logic rise;
   logic fall;

   always_comb begin
      // R1 R6 R20 gate then invert
      gated = (raw_cmp & cmp_on) ^ invert;
      // R5 per-cycle capture
      result_nxt = gated;
      prev_nxt = result_r;
      // R22 R13 R17 edge compare
      rise = result_r & ~prev_r;
      fall = ~result_r & prev_r;
      // R10 R11 re-latch on prescaled timer fall
      sync_nxt = tmr_fall ? result_r : sync_r;
      pin_nxt = sync_en ? sync_nxt : gated;
      // R14 R15 set wins over clear
      flag_nxt = (flag_r & ~flag_clr) | (rise & rise_en) | (fall & fall_en);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_r <= 1'h0;
         prev_r <= 1'h0;
         sync_r <= 1'h0;
         pin_val_r <= 1'h0;
         flag_r <= 1'h0;
      end else begin
         result_r <= result_nxt;
         prev_r <= prev_nxt;
         sync_r <= sync_nxt;
         pin_val_r <= pin_nxt;
         flag_r <= flag_nxt;
      end
   end

   a_flag_set: assert property (@(posedge clk) disable iff (!rst_n) // R14
      (rise & rise_en) |=> flag_r) else $error("flag missed rising edge");
   a_flag_hold: assert property (@(posedge clk) disable iff (!rst_n) // R15
      (flag_r & ~flag_clr) |=> flag_r) else $error("flag dropped without clear");
   a_clear_race: assert property (@(posedge clk) disable iff (!rst_n) // R15
      (flag_clr & fall & fall_en) |=> flag_r) else $error("clear beat edge");
   a_result_track: assert property (@(posedge clk) disable iff (!rst_n) // R6
      1'b1 |=> result_r == $past((raw_cmp & cmp_on) ^ invert))
      else $error("result wrong");
   a_sync_stable: assert property (@(posedge clk) disable iff (!rst_n) // R10
      (sync_en & ~tmr_fall & $past(sync_en) & ~$past(tmr_fall)) |=> $stable(pin_val_r))
      else $error("synced pin moved without timer edge");
   c_rise: cover property (@(posedge clk) disable iff (!rst_n) rise & rise_en);
   c_fall: cover property (@(posedge clk) disable iff (!rst_n) fall & fall_en);
   c_race: cover property (@(posedge clk) disable iff (!rst_n) flag_clr & rise & rise_en);
endmodule // dcc_chan

// File: rtl/dcc_top.sv
// Digital control around two analog comparators
// Notes on behaviour
// R1: Comparator works only while comparator_on is set; otherwise off.
// R2: Result shown in control result bit and mirror register bit.
// R3: Pin driven only with output enable, direction output, and comparator on.
// R4: Output enable overrides port latch regardless of comparator_on.
// R5: Internal result latched each instruction cycle; pin path not latched (code registers it each clock in pin_val_r, then PIN_OUT).
// R6: Invert clear gives plus-over-minus high; invert set complements.
// R7: speed_select resets to 1 normal; 0 is low power.
// R8: hysteresis_enable turns input hysteresis on or off.
// R9: Each result offered as gate source to the gated timer.
// R10: With sync enabled, result relatched on timer clock falling edge.
// R11: Sync latch uses the prescaled timer clock.
// R12: Timer counts on rising edge so synced value is stable.
// R13: Separate rising and falling edge detectors per comparator.
// R14: Enabled rising or falling edge sets the interrupt flag.
// R15: Only software clears flag; simultaneous edge keeps it set.
// R16: Software enables comparator, edges and interrupt enables for interrupts.
// R17: Edges seen after inversion and gating, even when disabled.
// R18: Two-bit positive select routes pin, DAC, reference or ground.
// R19: Comparator off disconnects every input source.
// R20: Raw output high when plus input exceeds minus input.
// R21: Three-bit negative select routes one source to minus input.
// R22: Edge found by comparing latched result with previous cycle's.
`timescale 1ns/10ps
module dcc_top
   import dcc_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [1:0] RAW_CMP,
   input wire logic [1:0] COMPARATOR_ON,
   input wire logic [1:0] PIN_OUTPUT_ENABLE,
   input wire logic [1:0] PIN_DIRECTION,
   input wire logic [1:0] PORT_LATCH,
   input wire logic [1:0] OUTPUT_INVERT,
   input wire logic [1:0] SPEED_WRITE,
   input wire logic [1:0] SPEED_WDATA,
   input wire logic [1:0] HYSTERESIS_ENABLE,
   input wire logic [1:0] TIMER_SYNC_ENABLE,
   input wire logic [1:0] RISE_IRQ_ENABLE,
   input wire logic [1:0] FALL_IRQ_ENABLE,
   input wire logic [1:0] FLAG_CLEAR,
   input wire logic [3:0] POSITIVE_INPUT_SELECT,
   input wire logic [5:0] NEGATIVE_INPUT_SELECT,
   input wire logic TMR_CLK_PRESCALED,
   input wire logic [1:0] TMR_GATE_SELECT,
   output logic [1:0] COMPARATOR_RESULT,
   output logic [1:0] MIRRORED_RESULT,
   output logic [1:0] PIN_OUT,
   output logic [1:0] PIN_OE_N,
   output logic [1:0] SPEED_SELECT,
   output logic [1:0] HYST_ON,
   output logic [1:0] ANALOG_POWER,
   output logic [7:0] POS_ROUTE,
   output logic [NSEL_NUM*2-1:0] NEG_ROUTE,
   output logic TMR_GATE
);
   logic rst_s1_r;
   logic rst_n_r;
   logic tclk_prev_r;
   logic tmr_fall;
   logic [1:0] result;
   logic [1:0] pin_val;
   logic [1:0] flag;
   logic [1:0] speed_nxt;
   logic [1:0] speed_r;
   logic [1:0] pin_out_nxt;
   logic [1:0] pin_oe_n_nxt;
   logic [7:0] pos_nxt;
   logic [NSEL_NUM*2-1:0] neg_nxt;
   logic gate_nxt;
   logic [1:0] hyst_nxt;
   logic [1:0] cmp_irq_flag;

   // One-hot routing of a select code; all off when the comparator is off
   function automatic logic [3:0] route4(input logic on, input logic [1:0] sel);
      logic [3:0] r;
      r = 4'h0;
      if (on) begin
         r[sel] = 1'b1;
      end
      return r;
   endfunction

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // R11 R12 falling edge of prescaled timer clock; timer counts on rising
   assign tmr_fall = tclk_prev_r & ~TMR_CLK_PRESCALED;

   for (genvar i = 0; i < DCC_NUM; i++) begin : g_ch
      dcc_chan u_chan (
         .clk(CLK),
         .rst_n(rst_n_r),
         .raw_cmp(RAW_CMP[i]),
         .cmp_on(COMPARATOR_ON[i]),
         .invert(OUTPUT_INVERT[i]),
         .sync_en(TIMER_SYNC_ENABLE[i]),
         .tmr_fall(tmr_fall),
         .rise_en(RISE_IRQ_ENABLE[i]),
         .fall_en(FALL_IRQ_ENABLE[i]),
         .flag_clr(FLAG_CLEAR[i]),
         .result_r(result[i]),
         .pin_val_r(pin_val[i]),
         .flag_r(flag[i])
      );
   end

   always_comb begin
      for (int i = 0; i < DCC_NUM; i++) begin
         // R7 speed written by software
         speed_nxt[i] = SPEED_WRITE[i] ? SPEED_WDATA[i] : speed_r[i];
         // R4 override of port latch independent of comparator_on
         pin_out_nxt[i] = PIN_OUTPUT_ENABLE[i] ? pin_val[i] : PORT_LATCH[i];
         // R3 drive only when enabled, output direction and on
         pin_oe_n_nxt[i] = ~(PIN_OUTPUT_ENABLE[i] & ~PIN_DIRECTION[i] & COMPARATOR_ON[i]);
         // R18 R19 positive routing
         pos_nxt[i*4 +: 4] = route4(COMPARATOR_ON[i], POSITIVE_INPUT_SELECT[i*2 +: 2]);
         // R21 R19 negative routing; codes above the last source select none
         neg_nxt[i*NSEL_NUM +: NSEL_NUM] = NEGATIVE_INPUT_SELECT[i*NSEL_W + 2] ? 4'h0 :
            route4(COMPARATOR_ON[i], NEGATIVE_INPUT_SELECT[i*NSEL_W +: 2]);
      end
      // R9 gate source choice
      gate_nxt = TMR_GATE_SELECT[0] ? pin_val[1] : pin_val[0];
      // R8 hysteresis only while the comparator is on
      hyst_nxt = HYSTERESIS_ENABLE & COMPARATOR_ON;
   end

   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tclk_prev_r <= 1'b0;
         speed_r <= {DCC_NUM{SPEED_RESET}};
         SPEED_SELECT <= {DCC_NUM{SPEED_RESET}};
         PIN_OUT <= 2'h0;
         PIN_OE_N <= 2'h3;
         COMPARATOR_RESULT <= 2'h0;
         MIRRORED_RESULT <= 2'h0;
         HYST_ON <= 2'h0;
         ANALOG_POWER <= 2'h0;
         POS_ROUTE <= 8'h00;
         NEG_ROUTE <= '0;
         TMR_GATE <= 1'b0;
      end else begin
         tclk_prev_r <= TMR_CLK_PRESCALED;
         speed_r <= speed_nxt;
         SPEED_SELECT <= speed_nxt;
         PIN_OUT <= pin_out_nxt;
         PIN_OE_N <= pin_oe_n_nxt;
         // R2 result and mirror
         COMPARATOR_RESULT <= result;
         MIRRORED_RESULT <= result;
         // R8 hysteresis
         HYST_ON <= hyst_nxt;
         // R1 power only while on
         ANALOG_POWER <= COMPARATOR_ON;
         POS_ROUTE <= pos_nxt;
         NEG_ROUTE <= neg_nxt;
         TMR_GATE <= gate_nxt;
      end
   end

   assign cmp_irq_flag = flag;

   a_pin_drive: assert property (@(posedge CLK) disable iff (!rst_n_r) // R3
      !PIN_OE_N[0] |-> $past(PIN_OUTPUT_ENABLE[0] & COMPARATOR_ON[0] & ~PIN_DIRECTION[0]))
      else $error("pin driven without all conditions");
   a_off_route: assert property (@(posedge CLK) disable iff (!rst_n_r) // R19
      !COMPARATOR_ON[1] |=> (POS_ROUTE[7:4] == 4'h0 && NEG_ROUTE[7:4] == 4'h0))
      else $error("inputs connected while off");
   a_speed_keep: assert property (@(posedge CLK) disable iff (!rst_n_r) // R7
      !SPEED_WRITE[0] |=> $stable(SPEED_SELECT[0])) else $error("speed changed");

   // R9 gate follows channel zero
   a_gate_zero: assert property (@(posedge CLK) disable iff (!rst_n_r) // R9
      !TMR_GATE_SELECT[0] |=> TMR_GATE == $past(pin_val[0]))
      else $error("gate not from channel zero");

   // R9 gate follows channel one
   a_gate_one: assert property (@(posedge CLK) disable iff (!rst_n_r) // R9
      TMR_GATE_SELECT[0] |=> TMR_GATE == $past(pin_val[1]))
      else $error("gate not from channel one");

   // R11 R12 strobe only on falling edge
   a_timer_fall: assert property (@(posedge CLK) disable iff (!rst_n_r) // R11
      tmr_fall |-> ($past(TMR_CLK_PRESCALED) && !TMR_CLK_PRESCALED))
      else $error("timer fall strobe without falling edge");

   // Guards per channel; the rst_n_r term keeps the release edge, whose outputs
   // still hold reset values, out of the antecedents
   for (genvar i = 0; i < DCC_NUM; i++) begin : g_chk
      // R3 drive when allowed
      a_pin_enable: assert property (@(posedge CLK) disable iff (!rst_n_r) // R3
         (rst_n_r && PIN_OUTPUT_ENABLE[i] && !PIN_DIRECTION[i] && COMPARATOR_ON[i])
         |=> !PIN_OE_N[i]) else $error("pin not driven when allowed");

      // R3 release otherwise
      a_pin_release: assert property (@(posedge CLK) disable iff (!rst_n_r) // R3
         (PIN_DIRECTION[i] || !PIN_OUTPUT_ENABLE[i] || !COMPARATOR_ON[i]) |=> PIN_OE_N[i])
         else $error("pin driven when not allowed");

      // R4 latch when not overridden
      a_latch_pass: assert property (@(posedge CLK) disable iff (!rst_n_r) // R4
         (rst_n_r && !PIN_OUTPUT_ENABLE[i]) |=> PIN_OUT[i] == $past(PORT_LATCH[i]))
         else $error("port latch not passed");

      // R4 result overrides latch
      a_pin_override: assert property (@(posedge CLK) disable iff (!rst_n_r) // R4
         PIN_OUTPUT_ENABLE[i] |=> PIN_OUT[i] == $past(pin_val[i]))
         else $error("result did not override latch");

      // R2 mirror equals result
      a_mirror_same: assert property (@(posedge CLK) disable iff (!rst_n_r) // R2
         MIRRORED_RESULT[i] == COMPARATOR_RESULT[i])
         else $error("mirror differs from result");

      // R6 polarity end to end
      a_result_path: assert property (@(posedge CLK) disable iff (!rst_n_r) // R6
         $past(rst_n_r, 2) |-> COMPARATOR_RESULT[i] ==
         $past((RAW_CMP[i] & COMPARATOR_ON[i]) ^ OUTPUT_INVERT[i], 2))
         else $error("result polarity path wrong");

      // R1 off means quiet
      a_off_quiet: assert property (@(posedge CLK) disable iff (!rst_n_r) // R1
         !COMPARATOR_ON[i] |=> (!ANALOG_POWER[i] && !HYST_ON[i]))
         else $error("analog active while off");

      // R1 on means powered
      a_on_power: assert property (@(posedge CLK) disable iff (!rst_n_r) // R1
         (rst_n_r && COMPARATOR_ON[i]) |=> ANALOG_POWER[i])
         else $error("comparator unpowered while on");

      // R8 hysteresis switched on
      a_hyst_on: assert property (@(posedge CLK) disable iff (!rst_n_r) // R8
         (rst_n_r && HYSTERESIS_ENABLE[i] && COMPARATOR_ON[i]) |=> HYST_ON[i])
         else $error("hysteresis not on");

      // R8 hysteresis switched off
      a_hyst_off: assert property (@(posedge CLK) disable iff (!rst_n_r) // R8
         !HYSTERESIS_ENABLE[i] |=> !HYST_ON[i])
         else $error("hysteresis not off");

      // R7 speed write lands
      a_speed_load: assert property (@(posedge CLK) disable iff (!rst_n_r) // R7
         (rst_n_r && SPEED_WRITE[i]) |=> SPEED_SELECT[i] == $past(SPEED_WDATA[i]))
         else $error("speed write lost");

      // R7 speed held between writes
      a_speed_hold: assert property (@(posedge CLK) disable iff (!rst_n_r) // R7
         !SPEED_WRITE[i] |=> $stable(SPEED_SELECT[i]))
         else $error("speed moved without write");

      // R18 one positive source
      a_pos_onehot: assert property (@(posedge CLK) disable iff (!rst_n_r) // R18
         (rst_n_r && COMPARATOR_ON[i]) |=> $onehot(POS_ROUTE[i*4 +: 4]))
         else $error("positive route not one-hot");

      // R18 pin code
      a_pos_pin: assert property (@(posedge CLK) disable iff (!rst_n_r) // R18
         (rst_n_r && COMPARATOR_ON[i] && POSITIVE_INPUT_SELECT[i*2 +: 2] == PSEL_PIN)
         |=> POS_ROUTE[i*4 +: 4] == 4'h1) else $error("pin source not routed");

      // R18 converter code
      a_pos_dac: assert property (@(posedge CLK) disable iff (!rst_n_r) // R18
         (rst_n_r && COMPARATOR_ON[i] && POSITIVE_INPUT_SELECT[i*2 +: 2] == PSEL_DAC)
         |=> POS_ROUTE[i*4 +: 4] == 4'h2) else $error("converter source not routed");

      // R18 reference code
      a_pos_fref: assert property (@(posedge CLK) disable iff (!rst_n_r) // R18
         (rst_n_r && COMPARATOR_ON[i] && POSITIVE_INPUT_SELECT[i*2 +: 2] == PSEL_FREF)
         |=> POS_ROUTE[i*4 +: 4] == 4'h4) else $error("reference source not routed");

      // R18 ground code
      a_pos_ground: assert property (@(posedge CLK) disable iff (!rst_n_r) // R18
         (rst_n_r && COMPARATOR_ON[i] && POSITIVE_INPUT_SELECT[i*2 +: 2] == PSEL_GND)
         |=> POS_ROUTE[i*4 +: 4] == 4'h8) else $error("ground source not routed");

      // R21 upper codes select none
      a_neg_none: assert property (@(posedge CLK) disable iff (!rst_n_r) // R21
         NEGATIVE_INPUT_SELECT[i*NSEL_W + 2] |=> NEG_ROUTE[i*NSEL_NUM +: NSEL_NUM] == 4'h0)
         else $error("negative route on for unused code");

      // R21 one negative source
      a_neg_onehot: assert property (@(posedge CLK) disable iff (!rst_n_r) // R21
         (rst_n_r && COMPARATOR_ON[i] && !NEGATIVE_INPUT_SELECT[i*NSEL_W + 2])
         |=> $onehot(NEG_ROUTE[i*NSEL_NUM +: NSEL_NUM])) else $error("negative route not one-hot");

      // R21 first code
      a_neg_first: assert property (@(posedge CLK) disable iff (!rst_n_r) // R21
         (rst_n_r && COMPARATOR_ON[i] && NEGATIVE_INPUT_SELECT[i*NSEL_W +: NSEL_W] == 3'h0)
         |=> NEG_ROUTE[i*NSEL_NUM +: NSEL_NUM] == 4'h1) else $error("first negative not routed");

      // R19 off disconnects all
      a_route_off: assert property (@(posedge CLK) disable iff (!rst_n_r) // R19
         !COMPARATOR_ON[i] |=> (POS_ROUTE[i*4 +: 4] == 4'h0 &&
         NEG_ROUTE[i*NSEL_NUM +: NSEL_NUM] == 4'h0)) else $error("input connected while off");

      // R15 flag kept until cleared
      a_flag_keep: assert property (@(posedge CLK) disable iff (!rst_n_r) // R15
         (cmp_irq_flag[i] && !FLAG_CLEAR[i]) |=> cmp_irq_flag[i])
         else $error("flag lost without clear");
   end
   c_pin: cover property (@(posedge CLK) disable iff (!rst_n_r) !PIN_OE_N[0]);
   c_flag: cover property (@(posedge CLK) disable iff (!rst_n_r) cmp_irq_flag[1]);
endmodule // dcc_top

// File: shared/dcc_pkg.sv
// Constants and types shared by the dual comparator control logic
package dcc_pkg;
   localparam int DCC_NUM = 2;
   localparam logic SPEED_RESET = 1'h1;
   localparam logic [1:0] PSEL_PIN = 2'h0;
   localparam logic [1:0] PSEL_DAC = 2'h1;
   localparam logic [1:0] PSEL_FREF = 2'h2;
   localparam logic [1:0] PSEL_GND = 2'h3;
   localparam int NSEL_W = 3;
   localparam int NSEL_NUM = 4;
   typedef enum logic [1:0] {
      SRC_PIN,
      SRC_DAC,
      SRC_FREF,
      SRC_GND
   } dcc_psrc_type;
endpackage

// File: test/dcc_asrc_model.sv
// Analog voltage sources that face both comparator inputs
`timescale 1ns/10ps
module dcc_asrc_model (
   input wire logic clk,
   input wire logic [15:0] vp,
   input wire logic [15:0] vn,
   output logic [1:0] raw
);
   always_ff @(posedge clk) begin
      raw[0] <= vp[7:0] > vn[7:0];
      raw[1] <= vp[15:8] > vn[15:8];
   end
endmodule // dcc_asrc_model

// File: test/tb_top.sv
// Self-checking bench for the dual comparator control logic
`timescale 1ns/10ps
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] on = 2'h0, oe = 2'h0, dir = 2'h3, lat = 2'h0, inv = 2'h0, spw = 2'h0;
   logic [1:0] spd = 2'h0, hys = 2'h0, syn = 2'h0, rie = 2'h0, fie = 2'h0, fclr = 2'h0;
   logic [1:0] gsel = 2'h0, raw, res, mir, pout, poen, spsel, hon, apw;
   logic [3:0] psel = 4'h0;
   logic [5:0] nsel = 6'h0;
   logic [7:0] pr, nr;
   logic [15:0] vp = 16'h0000, vn = 16'h0040;
   logic tclk = 1'b0;
   logic tg;
   int failures = 0;
   int compares = 0;
   always #2 clk = ~clk;
   dcc_asrc_model u_src (.clk(clk), .vp(vp), .vn(vn), .raw(raw));
   dcc_top uut (
      .CLK(clk), .RESETN(rst_n), .RAW_CMP(raw), .COMPARATOR_ON(on),
      .PIN_OUTPUT_ENABLE(oe), .PIN_DIRECTION(dir), .PORT_LATCH(lat), .OUTPUT_INVERT(inv),
      .SPEED_WRITE(spw), .SPEED_WDATA(spd), .HYSTERESIS_ENABLE(hys),
      .TIMER_SYNC_ENABLE(syn), .RISE_IRQ_ENABLE(rie), .FALL_IRQ_ENABLE(fie),
      .FLAG_CLEAR(fclr), .POSITIVE_INPUT_SELECT(psel), .NEGATIVE_INPUT_SELECT(nsel),
      .TMR_CLK_PRESCALED(tclk), .TMR_GATE_SELECT(gsel), .COMPARATOR_RESULT(res),
      .MIRRORED_RESULT(mir), .PIN_OUT(pout), .PIN_OE_N(poen), .SPEED_SELECT(spsel),
      .HYST_ON(hon), .ANALOG_POWER(apw), .POS_ROUTE(pr), .NEG_ROUTE(nr), .TMR_GATE(tg));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Levels only, so a few cycles past the two-stage latency is enough
   task automatic st;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic clr;
      @(posedge clk);
      fclr <= 2'h1;
      @(posedge clk);
      fclr <= 2'h0;
      st();
   endtask
   task automatic end_of_test;
      $display("Compares %0d, failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #20000;
      failures++;
      end_of_test();
   end
   initial begin
      repeat (2) @(posedge clk);
      #1;
      chk(spsel, 8'h03);
      chk(poen, 8'h03);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      spw <= 2'h1;
      @(posedge clk);
      spw <= 2'h0;
      on <= 2'h3;
      st();
      chk(spsel, 8'h02);
      chk(apw, 8'h03);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         vp <= k[0] ? 16'h0080 : 16'h0010;
         inv <= {1'b0, k[1]};
         st();
         chk(res, k[0] ^ k[1]);
         chk(mir, k[0] ^ k[1]);
      end
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         psel <= {2'h0, k[1:0]};
         nsel <= {3'h0, k[2:0]};
         st();
         chk(pr[3:0], 8'h01 << k[1:0]);
         chk(nr[3:0], (k < 4) ? 8'h01 << k : 8'h00);
      end
      @(posedge clk);
      on <= 2'h0;
      hys <= 2'h2;
      inv <= 2'h0;
      lat <= 2'h1;
      oe <= 2'h1;
      dir <= 2'h2;
      st();
      chk(apw, 8'h00);
      chk(pr, 8'h00);
      chk(nr, 8'h00);
      chk(hon, 8'h00);
      chk(pout[0], 8'h00);
      chk(poen, 8'h03);
      @(posedge clk);
      on <= 2'h3;
      st();
      chk(poen, 8'h02);
      chk(pout[0], 8'h01);
      chk(tg, 8'h01);
      chk(hon, 8'h02);
      @(posedge clk);
      oe <= 2'h0;
      lat <= 2'h0;
      gsel <= 2'h1;
      st();
      chk(pout[0], 8'h00);
      chk(poen, 8'h03);
      chk(tg, 8'h00);
      @(posedge clk);
      oe <= 2'h1;
      syn <= 2'h1;
      tclk <= 1'b1;
      st();
      @(posedge clk);
      tclk <= 1'b0;
      st();
      @(posedge clk);
      tclk <= 1'b1;
      vp <= 16'h0010;
      st();
      chk(res[0], 8'h00);
      chk(pout[0], 8'h01);
      @(posedge clk);
      tclk <= 1'b0;
      st();
      chk(pout[0], 8'h00);
      @(posedge clk);
      syn <= 2'h0;
      rie <= 2'h1;
      clr();
      chk(uut.g_ch[0].u_chan.flag_r, 8'h00);
      @(posedge clk);
      vp <= 16'h0080;
      st();
      chk(uut.g_ch[0].u_chan.flag_r, 8'h01);
      clr();
      chk(uut.g_ch[0].u_chan.flag_r, 8'h00);
      @(posedge clk);
      rie <= 2'h0;
      fie <= 2'h1;
      vp <= 16'h0010;
      st();
      chk(uut.g_ch[0].u_chan.flag_r, 8'h01);
      clr();
      @(posedge clk);
      vp <= 16'h0080;
      st();
      chk(uut.g_ch[0].u_chan.flag_r, 8'h00);
      // Clear lands on the edge that detects the fall
      @(posedge clk);
      vp <= 16'h0010;
      repeat (2) @(posedge clk);
      fclr <= 2'h1;
      @(posedge clk);
      fclr <= 2'h0;
      st();
      chk(uut.g_ch[0].u_chan.flag_r, 8'h01);
      @(posedge clk);
      on <= 2'h2;
      clr();
      @(posedge clk);
      rie <= 2'h1;
      inv <= 2'h1;
      st();
      chk(res[0], 8'h01);
      chk(uut.g_ch[0].u_chan.flag_r, 8'h01);
      end_of_test();
   end
endmodule // tb_top
